// ### bench/pmc_misc_cfg_props.sv
/* Checker for the misc config block: register port, gap,
   idle pattern and deep power-down exit. Bound to pmc_misc_cfg. */
`timescale 1ns/100ps
module pmc_misc_cfg_props #(
   parameter EXIT_FAST_CYC = 20,
   parameter EXIT_SLOW_CYC = 40,
   parameter BLINK_CYC = 4,
   parameter STRETCH_CYC = 8
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire [11:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire std_power_down_i,
   input wire interrupt_power_down_pin_i,
   input wire idle_tx_bit_o,
   input wire deep_power_down_o,
   input wire dpd_exiting_o,
   input wire [7:0] min_gap_cyc_o
);
   reg [31:0] exit_cnt_q;
   wire [31:0] exit_cnt_d;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Cycles spent in the current exit interval
   assign exit_cnt_d = dpd_exiting_o ? exit_cnt_q + 32'h1 : 32'h0;
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         exit_cnt_q <= 32'h0;
      end else begin
         exit_cnt_q <= exit_cnt_d;
      end
   end
   rdata_quiet_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0)
      else $error("read data outside read slot");
   dpd_resv_a: assert property (reg_rd_i && reg_addr_i == 12'h428
      |=> reg_rdata_o[15:6] == 10'h0) else $error("dpd reserved set");
   ind_resv_a: assert property (reg_rd_i && reg_addr_i == 12'h460
      |=> reg_rdata_o[15:12] == 4'h0) else $error("ind reserved set");
   gap_short_a: assert property (reg_wr_i && reg_addr_i == 12'h456
      && reg_wdata_i[1] |-> ##2 min_gap_cyc_o == 8'h18)
      else $error("short gap wrong");
   gap_long_a: assert property (reg_wr_i && reg_addr_i == 12'h456
      && !reg_wdata_i[1] |-> ##2 min_gap_cyc_o == 8'h28)
      else $error("long gap wrong");
   idle_one_a: assert property ($rose(idle_tx_bit_o) |=> !idle_tx_bit_o)
      else $error("idle one not followed by zero");
   dpd_gate_a: assert property ((!std_power_down_i &&
      !interrupt_power_down_pin_i)[*4] ##0 !deep_power_down_o
      |=> !deep_power_down_o) else $error("deep entry without power-down");
   exit_len_a: assert property ($fell(dpd_exiting_o) |->
      exit_cnt_q == EXIT_FAST_CYC || exit_cnt_q == EXIT_SLOW_CYC)
      else $error("exit duration wrong");
   exit_done_a: assert property ($fell(dpd_exiting_o) |-> !deep_power_down_o)
      else $error("deep mode outlives exit");
   exit_start_a: assert property ($rose(dpd_exiting_o) |-> deep_power_down_o)
      else $error("exit without deep mode");
   cover property ($fell(dpd_exiting_o));
   cover property ($rose(idle_tx_bit_o));
   cover property (reg_wr_i && reg_addr_i == 12'h456);
endmodule // pmc_misc_cfg_props
bind pmc_misc_cfg pmc_misc_cfg_props #(.EXIT_FAST_CYC(EXIT_FAST_CYC),
   .EXIT_SLOW_CYC(EXIT_SLOW_CYC), .BLINK_CYC(BLINK_CYC),
   .STRETCH_CYC(STRETCH_CYC)) u_props (.*);

// ### bench/pmc_misc_cfg_tb_top.sv
/* Self-checking bench for the misc config block.
   Drives every port directly; short exit counts via parameters. */
`timescale 1ns/100ps
module pmc_misc_cfg_tb_top;
   logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i;
   logic [11:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o;
   logic std_power_down_i, interrupt_power_down_pin_i;
   logic basic_status_read_i, self_test_clear_i, link_up_i, tx_act_i;
   logic rx_act_i, collision_i, speed100_i, full_duplex_i, lpi_i;
   logic mii_err_i, prbs_err_i, idle_tx_bit_o, idle_tx_active_o;
   logic deep_power_down_o, dpd_exiting_o;
   logic [7:0] min_gap_cyc_o;
   logic first_indicator_output_o, third_indicator_output_o;
   int miscompares = 0;
   int total_checks = 0;
   logic [4:0] lens [4] = '{5'h00, 5'h01, 5'h05, 5'h1f};
   logic [7:0] pats [3] = '{8'haa, 8'h55, 8'h8c};
   pmc_misc_cfg #(.EXIT_FAST_CYC(20), .EXIT_SLOW_CYC(40), .BLINK_CYC(4),
      .STRETCH_CYC(8)) uut (.*);
   // Free running 200 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask
   task automatic ind(input logic [1:0] exp);
      chk({14'h0, first_indicator_output_o, third_indicator_output_o},
         {14'h0, exp});
   endtask
   function automatic logic exp_ind(input logic [3:0] c, input logic [7:0] v);
      case (c)
         4'h0, 4'h8: return v[7];
         4'h1, 4'h9: return v[6] | v[5];
         4'h2: return v[6];
         4'h3: return v[5];
         4'h4: return v[4];
         4'h5: return v[3];
         4'h6: return !v[3];
         4'h7: return v[2];
         4'ha: return v[7] & v[3] & v[2];
         4'hb: return v[1];
         4'hc: return v[0];
         default: return 1'b0;
      endcase
   endfunction
   task automatic t_regs;
      rd(12'h428, 16'h0000);
      rd(12'h456, 16'h0002);
      rd(12'h460, 16'h0551);
      rd(12'h123, 16'h0000);
      chk({8'h0, min_gap_cyc_o}, 16'h0018);
      wr(12'h428, 16'hffc0);
      rd(12'h428, 16'h0000);
      wr(12'h460, 16'hffff);
      rd(12'h460, 16'h0fff);
      wr(12'h456, 16'ha5a5);
      rd(12'h456, 16'ha5a5);
      chk({8'h0, min_gap_cyc_o}, 16'h0028);
      wr(12'h456, 16'h0002);
      cyc(2);
      chk({8'h0, min_gap_cyc_o}, 16'h0018);
      $display("test regs done");
   endtask
   // Distance between ones gives the zero count
   task automatic t_idle;
      logic [79:0] s;
      int p;
      int q;
      for (int i = 0; i < 4; i++) begin
         wr(12'h027, {12'h0, lens[i][3:0]});
         wr(12'h428, {10'h0, lens[i][4], 5'h10});
         cyc(4);
         for (int j = 0; j < 80; j++) begin
            @(posedge sys_clk_i);
            #1 s[j] = idle_tx_bit_o;
         end
         p = -1;
         q = -1;
         for (int j = 79; j >= 0; j--) begin
            if (s[j] === 1'b1) begin
               q = p;
               p = j;
            end
         end
         chk({15'h0, idle_tx_active_o}, 16'h1);
         if (lens[i] == 5'h0) chk({15'h0, |s}, 16'h0);
         else chk(16'(q - p - 1), {11'h0, lens[i]});
      end
      wr(12'h428, 16'h0000);
      cyc(3);
      chk({15'h0, idle_tx_active_o}, 16'h0);
      $display("test idle done");
   endtask
   // Exit length in whole cycles of the exit flag
   task automatic meas(input int exp);
      int n = 0;
      for (int j = 0; j < 100 && (n == 0 || dpd_exiting_o === 1'b1); j++)
      begin
         #1 n += (dpd_exiting_o === 1'b1);
         @(posedge sys_clk_i);
      end
      chk(16'(n), 16'(exp));
      chk({15'h0, deep_power_down_o}, 16'h0);
   endtask
   task automatic t_dpd;
      wr(12'h428, 16'h0004);
      cyc(8);
      chk({15'h0, deep_power_down_o}, 16'h0);
      std_power_down_i <= 1'b1;
      cyc(6);
      chk({15'h0, deep_power_down_o}, 16'h1);
      wr(12'h428, 16'h000c);
      wr(12'h428, 16'h0008);
      meas(20);
      std_power_down_i <= 1'b0;
      interrupt_power_down_pin_i <= 1'b1;
      wr(12'h428, 16'h0004);
      cyc(6);
      chk({15'h0, deep_power_down_o}, 16'h1);
      wr(12'h428, 16'h0000);
      meas(40);
      interrupt_power_down_pin_i <= 1'b0;
      $display("test power-down done");
   endtask
   task automatic t_ind;
      logic e;
      for (int p = 0; p < 3; p++) begin
         {link_up_i, tx_act_i, rx_act_i, collision_i, speed100_i,
            full_duplex_i, lpi_i, mii_err_i} <= pats[p];
         cyc(20);
         for (int c = 0; c < 16; c++) begin
            if (c == 13 || c == 14 || (c == 8 && p != 2)) continue;
            e = exp_ind(4'(c), pats[p]);
            wr(12'h460, {4'h0, 4'(c), 4'(c), 4'h1});
            cyc(3);
            ind({e, e});
         end
      end
      $display("test indicator done");
   endtask
   task automatic seen(output logic h);
      h = 1'b0;
      repeat (20) begin
         @(posedge sys_clk_i);
         #1 h |= first_indicator_output_o;
      end
   endtask
   // Latched sources hold until their own clear
   task automatic t_latch;
      logic h;
      wr(12'h460, 16'h0dd1);
      basic_status_read_i <= 1'b1;
      cyc(1);
      basic_status_read_i <= 1'b0;
      cyc(4);
      ind(2'b00);
      link_up_i <= 1'b0;
      cyc(6);
      link_up_i <= 1'b1;
      cyc(6);
      ind(2'b11);
      basic_status_read_i <= 1'b1;
      cyc(1);
      basic_status_read_i <= 1'b0;
      cyc(4);
      ind(2'b00);
      wr(12'h460, 16'h0ee1);
      prbs_err_i <= 1'b1;
      cyc(1);
      prbs_err_i <= 1'b0;
      cyc(30);
      seen(h);
      chk({15'h0, h}, 16'h1);
      self_test_clear_i <= 1'b1;
      cyc(1);
      self_test_clear_i <= 1'b0;
      cyc(4);
      seen(h);
      chk({15'h0, h}, 16'h0);
      $display("test latch done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard, several times the expected run length
   initial begin
      #60000;
      miscompares++;
      complete_run;
   end
   // Main sequence
   initial begin
      rst_i = 1'b1;
      reg_addr_i = 12'h0;
      reg_wdata_i = 16'h0;
      {reg_wr_i, reg_rd_i, std_power_down_i, interrupt_power_down_pin_i,
         basic_status_read_i, self_test_clear_i, link_up_i, tx_act_i,
         rx_act_i, collision_i, speed100_i, full_duplex_i, lpi_i,
         mii_err_i, prbs_err_i} = '0;
      cyc(2);
      rst_i <= 1'b0;
      t_regs;
      t_idle;
      t_dpd;
      t_ind;
      t_latch;
      complete_run;
   end
endmodule // pmc_misc_cfg_tb_top

// ### verilog/pmc_defines.vh
/*
 Register offsets, field positions, reset values and timing counts of
 the miscellaneous power, gap and indicator configuration block.
 Assumes a 200 MHz system clock and a plain register port.
*/
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// Register offsets
`define PMC_ADDR_DPD 12'h428
`define PMC_ADDR_GEN 12'h456
`define PMC_ADDR_IND 12'h460
`define PMC_ADDR_PAT 12'h027

// Field positions
`define PMC_DPD_MSB 5
`define PMC_DPD_TEST 4
`define PMC_DPD_SPEED 3
`define PMC_DPD_EN 2
`define PMC_GEN_MIN 1
`define PMC_IND1_HI 11
`define PMC_IND1_LO 8
`define PMC_IND3_HI 7
`define PMC_IND3_LO 4

// Reset values
`define PMC_RST_DPD 16'h0000
`define PMC_RST_GEN 16'h0002
`define PMC_RST_IND 16'h0551
`define PMC_RST_PAT 4'h0

// Writable masks
`define PMC_WM_DPD 16'h003f
`define PMC_WM_GEN 16'hffff
`define PMC_WM_IND 16'h0fff

// Timing
`define PMC_CLK_MHZ 200
`define PMC_EXIT_FAST_MS 50
`define PMC_EXIT_SLOW_MS 100
`define PMC_GAP_SHORT_NS 120
`define PMC_GAP_LONG_NS 200
`define PMC_CYC_PER_MS (`PMC_CLK_MHZ * 1000)
`define PMC_GAP_SHORT_CYC ((`PMC_GAP_SHORT_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_GAP_LONG_CYC ((`PMC_GAP_LONG_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_BLINK_CYC 24'h989680
`define PMC_STRETCH_CYC 24'h4c4b40

`endif

// ### verilog/pmc_ind_mux.v
/*
 Indicator source selector: picks one status level from a 4-bit code.
 Assumes all source levels are already on the system clock.
*/
`timescale 1ns/100ps
module pmc_ind_mux (
   input wire [3:0] sel_i,
   input wire [15:0] src_i,
   output wire ind_o
);
   // Code 1111 is reserved and reads dark
   assign ind_o = (sel_i == 4'hf) ? 1'b0 : src_i[sel_i];
endmodule // pmc_ind_mux

// ### verilog/pmc_misc_cfg.v
/*
 Miscellaneous configuration block: idle-pattern test generator, deep
 power-down sequencing, inter-packet gap selection and two indicator
 outputs. Assumes status inputs arrive from other clock domains or pins
 and are synchronised here; register port is single-cycle, read data
 one cycle after the read strobe.
*/
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "pmc_defines.vh"
module pmc_misc_cfg #(
   parameter EXIT_FAST_CYC = `PMC_EXIT_FAST_MS * `PMC_CYC_PER_MS,
   parameter EXIT_SLOW_CYC = `PMC_EXIT_SLOW_MS * `PMC_CYC_PER_MS,
   parameter BLINK_CYC = `PMC_BLINK_CYC,
   parameter STRETCH_CYC = `PMC_STRETCH_CYC
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire [11:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   input wire std_power_down_i,
   input wire interrupt_power_down_pin_i,
   input wire basic_status_read_i,
   input wire self_test_clear_i,
   input wire link_up_i,
   input wire tx_act_i,
   input wire rx_act_i,
   input wire collision_i,
   input wire speed100_i,
   input wire full_duplex_i,
   input wire lpi_i,
   input wire mii_err_i,
   input wire prbs_err_i,
   output reg idle_tx_bit_o,
   output reg idle_tx_active_o,
   output reg deep_power_down_o,
   output reg dpd_exiting_o,
   output reg [7:0] min_gap_cyc_o,
   output reg first_indicator_output_o,
   output reg third_indicator_output_o
);
   // Power-down sequencer states
   localparam ST_RUN = 2'b00;
   localparam ST_DOWN = 2'b01;
   localparam ST_EXIT = 2'b10;

   reg [15:0] dpd_q;
   reg [15:0] gen_q;
   reg [15:0] ind_q;
   reg [3:0] pat_q;
   reg [1:0] st_q;
   reg [31:0] exit_cnt_q;
   reg [4:0] zero_cnt_q;
   reg [31:0] shreg_q;
   reg link_lost_q;
   reg prbs_hold_q;
   reg link_prev_q;
   reg [23:0] blink_cnt_q;
   reg blink_q;
   reg [23:0] stretch_cnt_q;
   reg [10:0] meta_q;
   reg [10:0] sync_q;
   wire [4:0] pat_len;
   wire [15:0] src;
   wire ind1;
   wire ind3;
   wire pd_ok;
   wire act;
   wire [31:0] gap_short_w;
   wire [31:0] gap_long_w;
   wire [31:0] stretch_w;

   // Full-width copies so the narrow registers take a deliberate slice
   assign gap_short_w = `PMC_GAP_SHORT_CYC;
   assign gap_long_w = `PMC_GAP_LONG_CYC;
   assign stretch_w = STRETCH_CYC;

   // Decode shared by write and read paths
   function hit;
      input [11:0] a;
      input [11:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // Two-flop synchronisers for every off-domain status level
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         meta_q <= 11'h000;
         sync_q <= 11'h000;
      end else begin
         meta_q <= {interrupt_power_down_pin_i, std_power_down_i,
            link_up_i, tx_act_i, rx_act_i, collision_i, speed100_i,
            full_duplex_i, lpi_i, mii_err_i, prbs_err_i};
         sync_q <= meta_q;
      end
   end

   // Register writes; reserved read-only bits never store
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         dpd_q <= `PMC_RST_DPD;
         gen_q <= `PMC_RST_GEN;
         ind_q <= `PMC_RST_IND;
         pat_q <= `PMC_RST_PAT;
      end else if (reg_wr_i) begin
         if (hit(reg_addr_i, `PMC_ADDR_DPD))
            dpd_q <= reg_wdata_i & `PMC_WM_DPD;
         if (hit(reg_addr_i, `PMC_ADDR_GEN))
            gen_q <= reg_wdata_i & `PMC_WM_GEN;
         if (hit(reg_addr_i, `PMC_ADDR_IND))
            ind_q <= reg_wdata_i & `PMC_WM_IND;
         if (hit(reg_addr_i, `PMC_ADDR_PAT))
            pat_q <= reg_wdata_i[3:0];
      end
   end

   // Read data one cycle after the strobe; unmapped reads return zero
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         if (hit(reg_addr_i, `PMC_ADDR_DPD))
            reg_rdata_o <= dpd_q;
         else if (hit(reg_addr_i, `PMC_ADDR_GEN))
            reg_rdata_o <= gen_q;
         else if (hit(reg_addr_i, `PMC_ADDR_IND))
            reg_rdata_o <= ind_q;
         else if (hit(reg_addr_i, `PMC_ADDR_PAT))
            reg_rdata_o <= {12'h000, pat_q};
         else
            reg_rdata_o <= 16'h0000;
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

   // Pattern length: MSB from power-down register, low nibble elsewhere
   assign pat_len = {dpd_q[`PMC_DPD_MSB], pat_q};

   // Idle pattern: a one, then pat_len zeros, repeating; a zero pat_len sends only zeros
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         zero_cnt_q <= 5'h00;
         shreg_q <= 32'h00000000;
         idle_tx_bit_o <= 1'b0;
         idle_tx_active_o <= 1'b0;
      end else if (!dpd_q[`PMC_DPD_TEST]) begin
         // Normal transmit path keeps the line
         zero_cnt_q <= 5'h00;
         shreg_q <= 32'h00000000;
         idle_tx_bit_o <= 1'b0;
         idle_tx_active_o <= 1'b0;
      end else if (pat_len == 5'h00) begin
         zero_cnt_q <= 5'h00;
         shreg_q <= 32'h00000000;
         idle_tx_bit_o <= 1'b0;
         idle_tx_active_o <= 1'b1;
      end else begin
         idle_tx_active_o <= 1'b1;
         if (zero_cnt_q == 5'h00) begin
            idle_tx_bit_o <= 1'b1;
            zero_cnt_q <= pat_len;
         end else begin
            idle_tx_bit_o <= 1'b0;
            zero_cnt_q <= zero_cnt_q - 5'h01;
         end
         shreg_q <= {shreg_q[30:0], (zero_cnt_q == 5'h00)};
      end
   end

   // Standard power-down by register or pin must already be in force
   assign pd_ok = sync_q[9] | sync_q[10];

   // Deep power-down entry and timed exit
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_q <= ST_RUN;
         exit_cnt_q <= 32'h00000000;
         deep_power_down_o <= 1'b0;
         dpd_exiting_o <= 1'b0;
      end else begin
         case (st_q)
            ST_RUN: begin
               dpd_exiting_o <= 1'b0;
               if (dpd_q[`PMC_DPD_EN] && pd_ok) begin
                  st_q <= ST_DOWN;
                  deep_power_down_o <= 1'b1;
               end
            end
            ST_DOWN: begin
               if (!dpd_q[`PMC_DPD_EN]) begin
                  st_q <= ST_EXIT;
                  dpd_exiting_o <= 1'b1;
                  // Duration latched at exit so a late change is ignored
                  if (dpd_q[`PMC_DPD_SPEED])
                     exit_cnt_q <= EXIT_FAST_CYC - 1;
                  else
                     exit_cnt_q <= EXIT_SLOW_CYC - 1;
               end
            end
            ST_EXIT: begin
               if (exit_cnt_q == 32'h00000000) begin
                  st_q <= ST_RUN;
                  deep_power_down_o <= 1'b0;
                  dpd_exiting_o <= 1'b0;
               end else begin
                  exit_cnt_q <= exit_cnt_q - 32'h00000001;
               end
            end
            default: begin
               st_q <= ST_RUN;
               deep_power_down_o <= 1'b0;
               dpd_exiting_o <= 1'b0;
            end
         endcase
      end
   end

   // Gap length in cycles; shorter gap intended only for MII
   always @(posedge sys_clk_i) begin
      if (rst_i)
         min_gap_cyc_o <= gap_short_w[7:0];
      else if (gen_q[`PMC_GEN_MIN])
         min_gap_cyc_o <= gap_short_w[7:0];
      else
         min_gap_cyc_o <= gap_long_w[7:0];
   end

   // Sticky link-lost and PRBS flags; a new event beats the clear
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         link_prev_q <= 1'b0;
         link_lost_q <= 1'b0;
         prbs_hold_q <= 1'b0;
      end else begin
         link_prev_q <= sync_q[8];
         if (link_prev_q && !sync_q[8])
            link_lost_q <= 1'b1;
         else if (basic_status_read_i)
            link_lost_q <= 1'b0;
         if (sync_q[0])
            prbs_hold_q <= 1'b1;
         else if (self_test_clear_i)
            prbs_hold_q <= 1'b0;
      end
   end

   // Blink clock and activity stretch
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         blink_cnt_q <= 24'h000000;
         blink_q <= 1'b0;
         stretch_cnt_q <= 24'h000000;
      end else begin
         if (blink_cnt_q == BLINK_CYC - 1) begin
            blink_cnt_q <= 24'h000000;
            blink_q <= ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 24'h000001;
         end
         if (act)
            stretch_cnt_q <= stretch_w[23:0];
         else if (stretch_cnt_q != 24'h000000)
            stretch_cnt_q <= stretch_cnt_q - 24'h000001;
      end
   end

   assign act = sync_q[7] | sync_q[6];

   // Source table shared by both indicators, indexed by code
   assign src = {1'b0,                                // 1111 reserved
      prbs_hold_q & blink_q,
      link_lost_q,
      sync_q[1],                                      // 1100
      sync_q[2],                                      // 1011
      sync_q[8] & sync_q[4] & sync_q[3],              // 1010
      act | (stretch_cnt_q != 24'h000000),            // 1001
      sync_q[8] & ~(act & blink_q),                   // 1000
      sync_q[3],
      ~sync_q[4],
      sync_q[4],
      sync_q[5],
      sync_q[6],
      sync_q[7],
      act,
      sync_q[8]};

   pmc_ind_mux u_ind1 (
      .sel_i(ind_q[`PMC_IND1_HI:`PMC_IND1_LO]),
      .src_i(src),
      .ind_o(ind1)
   );

   pmc_ind_mux u_ind3 (
      .sel_i(ind_q[`PMC_IND3_HI:`PMC_IND3_LO]),
      .src_i(src),
      .ind_o(ind3)
   );

   // Registered indicator drives
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         first_indicator_output_o <= 1'b0;
         third_indicator_output_o <= 1'b0;
      end else begin
         first_indicator_output_o <= ind1;
         third_indicator_output_o <= ind3;
      end
   end
endmodule // pmc_misc_cfg
